// ===== include/rate_pkg.sv
// constants for the sample rate and decimation control block
package rate_pkg;
    // ***********************************
    // register offsets
    // ***********************************
    localparam logic [7:0] IRQ_EN_ADDR = 8'h06;
    localparam logic [7:0] MODE_ADDR   = 8'h07;
    localparam logic [7:0] RATE_ADDR   = 8'h08;
    localparam logic [7:0] XL_ADDR     = 8'h0D;
    localparam logic [7:0] XH_ADDR     = 8'h0E;
    localparam logic [7:0] YL_ADDR     = 8'h0F;
    localparam logic [7:0] YH_ADDR     = 8'h10;
    localparam logic [7:0] ZL_ADDR     = 8'h11;
    localparam logic [7:0] ZH_ADDR     = 8'h12;
    localparam logic [7:0] DEC_ADDR    = 8'h30;
    // ***********************************
    // fields and reset values
    // ***********************************
    localparam int         WAKE_BIT   = 0;
    localparam int         ACQ_BIT    = 3;
    localparam int         DEC_MSB    = 3;
    localparam logic [7:0] RATE_RST   = 8'h10;
    localparam logic [7:0] DEC_RST    = 8'h00;
    localparam logic [7:0] BYTE_ZERO  = 8'h00;
    localparam logic [3:0] DEC_OFF    = 4'h0;
    localparam int         LPF_SHIFT  = 2;
    localparam int         AXIS_W     = 16;
    localparam int         FIFO_DEPTH = 16;
    localparam int         MHZ_PER_HZ = 1000;
    // ***********************************
    // rate code to rate in millihertz, zero for a code with no rate
    // ***********************************
    function automatic logic [19:0] rate_mhz(input logic [7:0] code);
        unique case (code)
            8'h10: rate_mhz = 20'h0_61A8;
            8'h11, 8'h08: rate_mhz = 20'h0_C350;
            8'h12, 8'h09: rate_mhz = 20'h0_F424;
            8'h13, 8'h0A: rate_mhz = 20'h1_86A0;
            8'h14, 8'h0B: rate_mhz = 20'h1_E848;
            8'h15, 8'h0C: rate_mhz = 20'h3_D090;
            8'h16, 8'h0D: rate_mhz = 20'h7_A120;
            8'h17, 8'h0E: rate_mhz = 20'hF_4240;
            default: rate_mhz = 20'h0_0000;
        endcase
    endfunction
    // decimation code to divisor
    function automatic logic [9:0] dec_div(input logic [3:0] code);
        unique case (code)
            4'h1: dec_div = 10'h002;
            4'h2: dec_div = 10'h004;
            4'h3: dec_div = 10'h005;
            4'h4: dec_div = 10'h008;
            4'h5: dec_div = 10'h00A;
            4'h6: dec_div = 10'h010;
            4'h7: dec_div = 10'h014;
            4'h8: dec_div = 10'h028;
            4'h9: dec_div = 10'h043;
            4'hA: dec_div = 10'h050;
            4'hB: dec_div = 10'h064;
            4'hC: dec_div = 10'h0C8;
            4'hD: dec_div = 10'h0FA;
            4'hE: dec_div = 10'h1F4;
            4'hF: dec_div = 10'h3E8;
            default: dec_div = 10'h001;
        endcase
    endfunction
endpackage

// ===== rtl/sample_rate_decimation_ctrl.sv
// sample rate generator, decimator, axis result registers and sample buffer
// How it works
// R1 - axis result registers refresh once per output rate period while awake and the buffer is not full
// R2 - with the acquisition enable set, each axis register refresh requests an interrupt
// R3 - wake sampling rate comes from the rate register at 0x08, eight rates
// R4 - codes 0x10 to 0x17 give 25 to 1000 Hz for slow hosts
// R5 - codes 0x08 to 0x0E give 50 to 1000 Hz for fast serial
// R6 - decimation field zero makes output rate equal internal rate
// R7 - decimation field bits 3:0 of 0x30 divide internal rate by table
// R8 - buffer, axis registers and interrupts run at the output rate
// R9 - low-pass filter always runs at the internal rate
// R10 - no sample loads into registers while a host transfer runs
// R11 - rate and decimation change only in standby; wake accepts mode writes only
// R12 - decimator counts internal strobes, restarts when the field is written
`timescale 1ns/10ps
`default_nettype none

module sample_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wp_q;
    logic [AW:0]      rp_q;
    logic             push;
    logic             pop;

    assign in_ready  = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
    assign out_valid = (wp_q != rp_q);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rp_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_q + (AW+1)'(push);
            rp_q <= rp_q + (AW+1)'(pop);
        end
    end
endmodule

module sample_rate_decimation_ctrl #(
    parameter longint CLK_HZ = 250_000_000
) (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    output logic      [7:0]           reg_rdata,
    input  wire logic                 bus_busy,
    input  wire logic signed [15:0]   axis_raw_x,
    input  wire logic signed [15:0]   axis_raw_y,
    input  wire logic signed [15:0]   axis_raw_z,
    output logic      [15:0]          axis_x_result,
    output logic      [15:0]          axis_y_result,
    output logic      [15:0]          axis_z_result,
    output logic                      idr_tick,
    output logic                      odr_tick,
    output logic                      new_sample_irq,
    output logic                      buf_valid,
    input  wire logic                 buf_ready,
    output logic      [47:0]          buf_data
);
    localparam longint PER_NUM = CLK_HZ * rate_pkg::MHZ_PER_HZ;
    localparam int     AW      = rate_pkg::AXIS_W;

    // ***********************************
    // register file
    // ***********************************
    logic [7:0]  rate_q;
    logic [7:0]  dec_q;
    logic        wake_q;
    logic        acq_en_q;
    logic [7:0]  rdata_q;
    logic        wr_rate;
    logic        wr_dec;
    logic        wr_mode;

    assign wr_mode = reg_wr && (reg_addr == rate_pkg::MODE_ADDR);
    assign wr_rate = reg_wr && !wake_q && (reg_addr == rate_pkg::RATE_ADDR); // see R11
    assign wr_dec  = reg_wr && !wake_q && (reg_addr == rate_pkg::DEC_ADDR);  // see R11

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rate_q   <= rate_pkg::RATE_RST;
            dec_q    <= rate_pkg::DEC_RST;
            wake_q   <= 1'b0;
            acq_en_q <= 1'b0;
        end else begin
            if (wr_mode) begin
                wake_q <= reg_wdata[rate_pkg::WAKE_BIT];
            end
            if (wr_rate) begin
                rate_q <= reg_wdata; // see R3
            end
            if (wr_dec) begin
                dec_q <= reg_wdata; // see R7
            end
            if (reg_wr && !wake_q && (reg_addr == rate_pkg::IRQ_EN_ADDR)) begin // see R11
                acq_en_q <= reg_wdata[rate_pkg::ACQ_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_q <= rate_pkg::BYTE_ZERO;
        end else if (reg_rd) begin
            unique case (reg_addr)
                rate_pkg::IRQ_EN_ADDR: rdata_q <= 8'(acq_en_q) << rate_pkg::ACQ_BIT;
                rate_pkg::MODE_ADDR:   rdata_q <= 8'(wake_q) << rate_pkg::WAKE_BIT;
                rate_pkg::RATE_ADDR:   rdata_q <= rate_q;
                rate_pkg::DEC_ADDR:    rdata_q <= dec_q;
                rate_pkg::XL_ADDR:     rdata_q <= axis_x_result[7:0];
                rate_pkg::XH_ADDR:     rdata_q <= axis_x_result[15:8];
                rate_pkg::YL_ADDR:     rdata_q <= axis_y_result[7:0];
                rate_pkg::YH_ADDR:     rdata_q <= axis_y_result[15:8];
                rate_pkg::ZL_ADDR:     rdata_q <= axis_z_result[7:0];
                rate_pkg::ZH_ADDR:     rdata_q <= axis_z_result[15:8];
                default:               rdata_q <= rate_pkg::BYTE_ZERO;
            endcase
        end
    end
    assign reg_rdata = rdata_q;

    // ***********************************
    // internal rate strobe
    // ***********************************
    logic [19:0] mhz;
    logic [31:0] period;
    logic [31:0] per_cnt_q;
    logic        rate_ok;

    assign mhz     = rate_pkg::rate_mhz(rate_q); // see R4 R5
    assign rate_ok = (mhz != '0);
    assign period  = rate_ok ? 32'(PER_NUM / longint'(mhz)) : 32'd1;
    assign idr_tick = wake_q && rate_ok && (per_cnt_q == period - 32'd1); // see R3

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            per_cnt_q <= '0;
        end else if (!wake_q || !rate_ok || idr_tick || wr_rate) begin
            per_cnt_q <= '0;
        end else begin
            per_cnt_q <= per_cnt_q + 32'd1;
        end
    end

    // ***********************************
    // decimator
    // ***********************************
    logic [3:0] dec_code;
    logic [9:0] dec_cnt_q;
    logic       dec_term;

    assign dec_code = dec_q[rate_pkg::DEC_MSB:0];
    assign dec_term = (dec_code == rate_pkg::DEC_OFF)
                   || (dec_cnt_q == rate_pkg::dec_div(dec_code) - 10'd1); // see R6 R7
    assign odr_tick = idr_tick && dec_term; // see R12

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dec_cnt_q <= '0;
        end else if (wr_dec || !wake_q) begin
            dec_cnt_q <= '0; // see R12
        end else if (idr_tick) begin
            dec_cnt_q <= dec_term ? 10'd0 : dec_cnt_q + 10'd1; // see R12
        end
    end

    // ***********************************
    // low-pass filter at the internal rate
    // ***********************************
    logic signed [AW-1:0] filt_q [3];
    logic signed [AW-1:0] raw [3];
    assign raw[0] = axis_raw_x;
    assign raw[1] = axis_raw_y;
    assign raw[2] = axis_raw_z;

    for (genvar i = 0; i < 3; i++) begin : g_lpf
        always_ff @(posedge clk) begin
            if (!rst_b) begin
                filt_q[i] <= '0;
            end else if (idr_tick) begin
                filt_q[i] <= AW'(filt_q[i] + ((raw[i] - filt_q[i]) >>> rate_pkg::LPF_SHIFT)); // see R9
            end
        end
    end

    // ***********************************
    // output rate load of axis registers and buffer
    // ***********************************
    logic        pend_q;
    logic        load;
    logic        fifo_ready;
    logic [15:0] x_q;
    logic [15:0] y_q;
    logic [15:0] z_q;
    logic        irq_q;

    // a sample waits while the host transfers or the buffer is full
    assign load = (odr_tick || pend_q) && !bus_busy && fifo_ready; // see R8 R10

    always_ff @(posedge clk) begin
        if (!rst_b || !wake_q) begin
            pend_q <= 1'b0;
        end else if (load) begin
            pend_q <= 1'b0;
        end else if (odr_tick) begin
            pend_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            x_q <= '0;
            y_q <= '0;
            z_q <= '0;
        end else if (load) begin
            x_q <= filt_q[0]; // see R1
            y_q <= filt_q[1];
            z_q <= filt_q[2];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= load && acq_en_q; // see R2
        end
    end

    assign axis_x_result  = x_q;
    assign axis_y_result  = y_q;
    assign axis_z_result  = z_q;
    assign new_sample_irq = irq_q;

    sample_fifo #(
        .WIDTH (3 * AW),
        .DEPTH (rate_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (load),
        .in_ready  (fifo_ready),
        .in_data   ({filt_q[2], filt_q[1], filt_q[0]}),
        .out_valid (buf_valid),
        .out_ready (buf_ready),
        .out_data  (buf_data)
    );

    // ***********************************
    // checks
    // ***********************************
    sequence s_sample_due;
        odr_tick && !bus_busy && fifo_ready;
    endsequence
    sequence s_loaded;
        ##1 ($past(load) && x_q == $past(filt_q[0]));
    endsequence

    AST_LOAD_ON_ODR: assert property (@(posedge clk) disable iff (!rst_b) // see R1
        s_sample_due |-> s_loaded) else $error("axis registers not refreshed");
    AST_IRQ_ON_LOAD: assert property (@(posedge clk) disable iff (!rst_b) // see R2
        load && acq_en_q |=> new_sample_irq) else $error("missing sample interrupt");
    AST_IRQ_CAUSE: assert property (@(posedge clk) disable iff (!rst_b) // see R2
        new_sample_irq |-> $past(load) && $past(acq_en_q)) else $error("spurious sample interrupt");
    AST_NO_TICK_IDLE: assert property (@(posedge clk) disable iff (!rst_b) // see R3
        (!wake_q || !rate_ok) |-> !idr_tick) else $error("tick without valid rate");
    AST_ODR_EQ_IDR: assert property (@(posedge clk) disable iff (!rst_b) // see R6
        dec_code == rate_pkg::DEC_OFF |-> odr_tick == idr_tick) else $error("undivided rate differs");
    AST_ODR_ON_IDR: assert property (@(posedge clk) disable iff (!rst_b) // see R7
        odr_tick |-> idr_tick && dec_cnt_q < rate_pkg::dec_div(dec_code)) else $error("bad output strobe");
    AST_LOAD_AT_ODR: assert property (@(posedge clk) disable iff (!rst_b) // see R8
        load |-> odr_tick || pend_q) else $error("load off output rate");
    AST_LPF_HOLD: assert property (@(posedge clk) disable iff (!rst_b) // see R9
        !idr_tick |=> $stable(filt_q[0])) else $error("filter moved off internal rate");
    AST_BUSY_HOLD: assert property (@(posedge clk) disable iff (!rst_b) // see R10
        bus_busy |=> $stable(x_q) && !$past(load)) else $error("load during host transfer");
    AST_WAKE_LOCK: assert property (@(posedge clk) disable iff (!rst_b) // see R11
        wake_q && reg_wr && reg_addr != rate_pkg::MODE_ADDR |=> $stable(rate_q) && $stable(dec_q))
        else $error("setting changed while awake");
    AST_DEC_RESTART: assert property (@(posedge clk) disable iff (!rst_b) // see R12
        wr_dec |=> dec_cnt_q == 10'd0) else $error("decimator not restarted");
endmodule

`default_nettype wire

// ===== test/sample_drain_model.sv
// drain side partner for the sample buffer, can stall and counts popped words
`timescale 1ns/10ps
`default_nettype none

module sample_drain_model (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic stall,
    input  wire logic buf_valid,
    output logic      buf_ready,
    output int        pops
);
    // ***********************************
    // ready changes only just after a rising edge
    // ***********************************
    always_ff @(posedge clk) begin
        buf_ready <= rst_b && !stall;
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pops <= 0;
        end else if (buf_valid && buf_ready) begin
            pops <= pops + 1;
        end
    end
endmodule

`default_nettype wire

// ===== test/sample_rate_decimation_ctrl_test.sv
// self-checking bench for the sample rate and decimation control block
`timescale 1ns/10ps
`default_nettype none

module sample_rate_decimation_ctrl_test;
    localparam longint HZ = 50_000;
    logic               clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, bus_busy = 1'b0, stall = 1'b0;
    logic        [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_v;
    logic signed [15:0] raw_x = 16'h0400, raw_y = 16'hFE00, raw_z = 16'h0100, f_x, f_y, f_z, e_x, e_y, e_z;
    logic        [15:0] res_x, res_y, res_z;
    logic        [47:0] bdata;
    logic               idr_tick, odr_tick, irq, buf_valid, buf_ready;
    int                 n_errors = 0, n_compared = 0, n, m, p0, pops;
    logic        [7:0]  codes [15] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
                                       8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E};
    int                 per [15] = '{2000, 1000, 800, 500, 400, 200, 100, 50, 1000, 800, 500, 400, 200, 100, 50};
    int                 divs [10] = '{1, 2, 4, 5, 8, 10, 16, 20, 40, 67};

    always #2 clk = ~clk;

    sample_rate_decimation_ctrl #(.CLK_HZ(HZ)) sample_rate_decimation_ctrl_i (
        .clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .bus_busy(bus_busy),
        .axis_raw_x(raw_x), .axis_raw_y(raw_y), .axis_raw_z(raw_z),
        .axis_x_result(res_x), .axis_y_result(res_y), .axis_z_result(res_z),
        .idr_tick(idr_tick), .odr_tick(odr_tick), .new_sample_irq(irq),
        .buf_valid(buf_valid), .buf_ready(buf_ready), .buf_data(bdata)
    );
    sample_drain_model sample_drain_model_i (
        .clk(clk), .rst_b(rst_b), .stall(stall), .buf_valid(buf_valid), .buf_ready(buf_ready), .pops(pops)
    );

    // ***********************************
    // reference low-pass filter on all three axes, stepped by internal rate strobes
    // ***********************************
    always @(posedge clk) begin
        if (!rst_b) begin
            f_x <= 16'h0000;
            f_y <= 16'h0000;
            f_z <= 16'h0000;
        end else if (idr_tick === 1'b1) begin
            f_x <= f_x + ((raw_x - f_x) >>> 2);
            f_y <= f_y + ((raw_y - f_y) >>> 2);
            f_z <= f_z + ((raw_z - f_z) >>> 2);
        end
    end

    // ***********************************
    // bus tasks and comparison
    // ***********************************
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        rd_v = reg_rdata;
    endtask
    // cycles to the next strobe and internal strobes seen meanwhile
    task automatic wait_tick(input bit odr, output int cyc, output int idrs);
        cyc = 0;
        idrs = 0;
        do begin
            @(negedge clk);
            cyc++;
            if (idr_tick === 1'b1) idrs++;
        end while (((odr ? odr_tick : idr_tick) !== 1'b1) && cyc < 10000);
    endtask
    task automatic wrap_up;
        if (n_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(4 * 65000);
        n_errors++;
        wrap_up();
    end

    // ***********************************
    // test sequence
    // ***********************************
    initial begin
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        rd(rate_pkg::RATE_ADDR);
        chk("rate reset", 16'(rate_pkg::RATE_RST), 16'(rd_v));
        rd(rate_pkg::DEC_ADDR);
        chk("decimation reset", 16'h0000, 16'(rd_v));
        rd(8'hFF);
        chk("unmapped read", 16'h0000, 16'(rd_v));
        for (int i = 0; i < 15; i++) begin
            wr(rate_pkg::RATE_ADDR, codes[i]);
            rd(rate_pkg::RATE_ADDR);
            chk("rate readback", 16'(codes[i]), 16'(rd_v));
            wr(rate_pkg::MODE_ADDR, 8'h01);
            wait_tick(1'b0, n, m);
            wait_tick(1'b0, n, m);
            chk("internal period", 16'(per[i]), 16'(n));
            wr(rate_pkg::MODE_ADDR, 8'h00);
        end
        for (int c = 0; c < 10; c++) begin
            wr(rate_pkg::DEC_ADDR, 8'(c));
            wr(rate_pkg::MODE_ADDR, 8'h01);
            wait_tick(1'b1, n, m);
            wait_tick(1'b1, n, m);
            chk("decimation ratio", 16'(divs[c]), 16'(m));
            wr(rate_pkg::MODE_ADDR, 8'h00);
        end
        wr(rate_pkg::DEC_ADDR, 8'h02);
        wr(rate_pkg::IRQ_EN_ADDR, 8'h08);
        wr(rate_pkg::MODE_ADDR, 8'h01);
        wr(rate_pkg::RATE_ADDR, 8'h13);
        rd(rate_pkg::RATE_ADDR);
        chk("rate locked in wake", 16'(codes[14]), 16'(rd_v));
        wr(rate_pkg::DEC_ADDR, 8'h05);
        rd(rate_pkg::DEC_ADDR);
        chk("decimation locked in wake", 16'h0002, 16'(rd_v));
        for (int k = 0; k < 3; k++) begin
            wait_tick(1'b1, n, m);
            e_x = f_x;
            e_y = f_y;
            e_z = f_z;
            @(negedge clk);
            chk("x result at output rate", e_x, res_x);
            chk("y result at output rate", e_y, res_y);
            chk("z result at output rate", e_z, res_z);
            chk("acquisition request", 16'h0001, 16'(irq));
            chk("buffer holds word", 16'h0001, 16'(buf_valid));
            chk("buffer word x", e_x, bdata[15:0]);
            chk("buffer word y", e_y, bdata[31:16]);
            chk("buffer word z", e_z, bdata[47:32]);
        end
        // a strobe during a host transfer waits until the transfer ends
        bus_busy = 1'b1;
        wait_tick(1'b1, n, m);
        e_x = res_x;
        @(negedge clk);
        chk("x held while busy", e_x, res_x);
        chk("no request while busy", 16'h0000, 16'(irq));
        e_x = f_x;
        bus_busy = 1'b0;
        @(negedge clk);
        chk("x after transfer", e_x, res_x);
        chk("request after transfer", 16'h0001, 16'(irq));
        // fill the buffer with the drain stalled, then empty it
        wait_tick(1'b1, n, m);
        stall = 1'b1;
        repeat (18) wait_tick(1'b1, n, m);
        wr(rate_pkg::MODE_ADDR, 8'h00);
        p0 = pops;
        stall = 1'b0;
        repeat (40) @(negedge clk);
        chk("words drained", 16'd16, 16'(pops - p0));
        chk("buffer empty", 16'h0000, 16'(buf_valid));
        // a code outside both rate sets gives no internal strobe
        wr(rate_pkg::RATE_ADDR, 8'h0F);
        wr(rate_pkg::MODE_ADDR, 8'h01);
        wait_tick(1'b0, n, m);
        chk("no strobe on unlisted code", 16'h2710, 16'(n));
        wr(rate_pkg::MODE_ADDR, 8'h00);
        wrap_up();
    end
endmodule

`default_nettype wire
